// ===== shared/mpa_pkg.sv
// Constants, types and register map of the memory-pair ALU execution block
package mpa_pkg;

  // Operations of the group
  typedef enum logic [2:0] {
    MPA_OP_NONE  = 3'b000,
    MPA_OP_ADC   = 3'b001,
    MPA_OP_ADDNC = 3'b010,
    MPA_OP_SUB   = 3'b011,
    MPA_OP_SBB   = 3'b100,
    MPA_OP_SUBNB = 3'b101,
    MPA_OP_AND   = 3'b110,
    MPA_OP_OR    = 3'b111
  } mpa_op_t;

  // Opcode encodings
  localparam logic [7:0] FIRST_BYTE      = 8'h70;
  localparam logic [4:0] CODE_ADC        = 5'h1A;
  localparam logic [4:0] CODE_ADDNC      = 5'h14;
  localparam logic [4:0] CODE_SUB        = 5'h1C;
  localparam logic [4:0] CODE_SBB        = 5'h1E;
  localparam logic [4:0] CODE_SUBNB      = 5'h16;
  localparam logic [4:0] CODE_AND        = 5'h11;
  localparam logic [4:0] CODE_OR         = 5'h13;

  // Pointer mode field codes
  localparam logic [2:0] PTR_BC          = 3'h1;
  localparam logic [2:0] PTR_DE          = 3'h2;
  localparam logic [2:0] PTR_HL          = 3'h3;
  localparam logic [2:0] PTR_DE_INC      = 3'h4;
  localparam logic [2:0] PTR_HL_INC      = 3'h5;
  localparam logic [2:0] PTR_DE_DEC      = 3'h6;
  localparam logic [2:0] PTR_HL_DEC      = 3'h7;

  // Pair identifiers
  localparam logic [1:0] PAIR_BC         = 2'h0;
  localparam logic [1:0] PAIR_DE         = 2'h1;
  localparam logic [1:0] PAIR_HL         = 2'h2;

  // Timing: one state is one clock cycle
  localparam int         STATE_CYCLES    = 1;
  localparam int         STATES_EXEC     = 11;
  localparam int         STATES_OMIT     = 8;
  localparam logic [3:0] CNT_EXEC        = 4'(STATES_EXEC * STATE_CYCLES - 1);
  localparam logic [3:0] CNT_OMIT        = 4'(STATES_OMIT * STATE_CYCLES - 1);

  // Register offsets
  localparam logic [3:0] REG_ACC         = 4'h0;
  localparam logic [3:0] REG_B           = 4'h1;
  localparam logic [3:0] REG_C           = 4'h2;
  localparam logic [3:0] REG_D           = 4'h3;
  localparam logic [3:0] REG_E           = 4'h4;
  localparam logic [3:0] REG_H           = 4'h5;
  localparam logic [3:0] REG_L           = 4'h6;
  localparam logic [3:0] REG_FLAGS       = 4'h7;
  localparam logic [3:0] REG_STATUS      = 4'h8;

  // Flag register bit positions
  localparam int         FLG_CARRY       = 0;
  localparam int         FLG_HALF        = 1;
  localparam int         FLG_ZERO        = 2;
  localparam int         FLG_OMIT        = 3;
  localparam int         FLG_LOAD_LO     = 4;
  localparam int         FLG_LOAD_HI     = 5;
  localparam int         FLG_WIDTH       = 6;

  // Status register bit positions
  localparam int         STS_BUSY        = 0;
  localparam int         STS_ILLEGAL     = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [5:0] RST_FLAGS       = 6'h00;

endpackage

// ===== core/mpa_alu.sv
// Combinational arithmetic and logic unit for the memory-pair group
`timescale 1ns/1ps
module mpa_alu
  import mpa_pkg::*;
(
  input  wire mpa_op_t    op,
  input  wire logic [7:0] accIn,
  input  wire logic [7:0] memIn,
  input  wire logic       carryIn,
  output logic      [7:0] result,
  output logic            carryOut,
  output logic            halfOut,
  output logic            zeroOut,
  output logic            skipOut,
  output logic            arith
);

  logic [8:0] wide;
  logic [4:0] nib;
  logic       cin;

  // Adders share one path; subtraction reports borrow as carry
  always_comb
  begin
    wide     = 9'h000;
    nib      = 5'h00;
    result   = accIn;
    carryOut = 1'b0;
    halfOut  = 1'b0;
    skipOut  = 1'b0;
    arith    = 1'b1;
    cin      = ((op == MPA_OP_ADC) || (op == MPA_OP_SBB)) ? carryIn : 1'b0;
    case (op)
      MPA_OP_ADC, MPA_OP_ADDNC:
      begin
        wide     = {1'b0, accIn} + {1'b0, memIn} + {8'h00, cin};
        nib      = {1'b0, accIn[3:0]} + {1'b0, memIn[3:0]} + {4'h0, cin};
        result   = wide[7:0];
        carryOut = wide[8];
        halfOut  = nib[4];
        skipOut  = (op == MPA_OP_ADDNC) && !wide[8];
      end
      MPA_OP_SUB, MPA_OP_SBB, MPA_OP_SUBNB:
      begin
        wide     = {1'b0, accIn} - {1'b0, memIn} - {8'h00, cin};
        nib      = {1'b0, accIn[3:0]} - {1'b0, memIn[3:0]} - {4'h0, cin};
        result   = wide[7:0];
        carryOut = wide[8];
        halfOut  = nib[4];
        skipOut  = (op == MPA_OP_SUBNB) && !wide[8];
      end
      MPA_OP_AND:
      begin
        result = accIn & memIn;
        arith  = 1'b0;
      end
      MPA_OP_OR:
      begin
        result = accIn | memIn;
        arith  = 1'b0;
      end
      default:
      begin
        arith = 1'b0;
      end
    endcase
  end

  assign zeroOut = (result == 8'h00);

endmodule

// ===== core/mpa_mem_pair_alu.sv
// Execution of the accumulator/memory-pair instruction group with register port
`timescale 1ns/1ps
module mpa_mem_pair_alu
  import mpa_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Instruction hand-in
  input  wire logic              instValid,
  input  wire logic [7:0]        instByte0,
  input  wire logic [7:0]        instByte1,
  output logic                   instReady_r,
  output logic                   instDone_r,
  output logic                   omitActive_r,
  // Data memory read port
  output logic [ADDR_W-1:0]      memAddr_r,
  output logic                   memRd_r,
  input  wire logic [7:0]        memRdData,
  // Register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [7:0]             regRdData_r
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_EXEC = 3'b010,
    ST_HOLD = 3'b011
  } mpa_state_t;

  mpa_state_t           state_r;
  mpa_state_t           state_nxt;
  logic [3:0]           cnt_r;
  logic [7:0]           acc_r;
  logic [7:0]           regB_r;
  logic [7:0]           regC_r;
  logic [7:0]           regD_r;
  logic [7:0]           regE_r;
  logic [7:0]           regH_r;
  logic [7:0]           regL_r;
  logic [FLG_WIDTH-1:0] flags_r;
  logic                 illegal_r;
  mpa_op_t              op_r;
  logic [2:0]           ptrMode_r;
  logic [15:0]          ptrBase_r;
  logic [7:0]           aluRes;
  logic                 aluCarry;
  logic                 aluHalf;
  logic                 aluZero;
  logic                 aluSkip;
  logic                 aluArith;
  logic                 accept;
  logic                 decOk;
  mpa_op_t              decOp;
  logic                 doExec;
  logic                 swWrite;
  logic [15:0]          ptrNext;
  logic [1:0]           pairId;

  // Second byte top five bits to operation
  function automatic mpa_op_t decodeOp(input logic [7:0] b0, input logic [7:0] b1);
    mpa_op_t o;
    o = MPA_OP_NONE;
    if (b0 == FIRST_BYTE)
    begin
      case (b1[7:3])
        CODE_ADC:   o = MPA_OP_ADC;
        CODE_ADDNC: o = MPA_OP_ADDNC;
        CODE_SUB:   o = MPA_OP_SUB;
        CODE_SBB:   o = MPA_OP_SBB;
        CODE_SUBNB: o = MPA_OP_SUBNB;
        CODE_AND:   o = MPA_OP_AND;
        CODE_OR:    o = MPA_OP_OR;
        default:    o = MPA_OP_NONE;
      endcase
    end
    return o;
  endfunction

  // Pointer mode to pair identifier
  function automatic logic [1:0] pairOf(input logic [2:0] mode);
    logic [1:0] p;
    case (mode)
      PTR_BC:                         p = PAIR_BC;
      PTR_DE, PTR_DE_INC, PTR_DE_DEC: p = PAIR_DE;
      default:                        p = PAIR_HL;
    endcase
    return p;
  endfunction

  // Current value of a pair
  function automatic logic [15:0] pairValue(input logic [1:0] p, input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] d, input logic [7:0] e,
                                            input logic [7:0] h, input logic [7:0] l);
    logic [15:0] v;
    case (p)
      PAIR_BC: v = {b, c};
      PAIR_DE: v = {d, e};
      default: v = {h, l};
    endcase
    return v;
  endfunction

  mpa_alu u_alu (
    .op       (op_r),
    .accIn    (acc_r),
    .memIn    (memRdData),
    .carryIn  (flags_r[FLG_CARRY]),
    .result   (aluRes),
    .carryOut (aluCarry),
    .halfOut  (aluHalf),
    .zeroOut  (aluZero),
    .skipOut  (aluSkip),
    .arith    (aluArith)
  );

  // Hand-in and decode
  assign accept = instValid && instReady_r;
  assign decOp  = decodeOp(instByte0, instByte1);
  assign decOk  = (decOp != MPA_OP_NONE) && (instByte1[2:0] != 3'h0);
  assign doExec = (state_r == ST_EXEC);
  assign pairId = pairOf(ptrMode_r);
  // Software may not disturb the programmer state while an instruction owns it
  assign swWrite = regWr && (state_r == ST_IDLE) && !accept;

  // Post-access pointer value, wrapping in 16 bits
  always_comb
  begin
    case (ptrMode_r)
      PTR_DE_INC, PTR_HL_INC: ptrNext = ptrBase_r + 16'h0001;
      PTR_DE_DEC, PTR_HL_DEC: ptrNext = ptrBase_r - 16'h0001;
      default:                ptrNext = ptrBase_r;
    endcase
  end

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (accept && !flags_r[FLG_OMIT] && decOk)
        begin
          state_nxt = ST_READ;
        end
        else if (accept)
        begin
          state_nxt = ST_HOLD;
        end
      end
      ST_READ: state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = ST_HOLD;
      ST_HOLD:
      begin
        if (cnt_r == 4'h0)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // State counter: busy lasts the full instruction time
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
    end
    else if (accept)
    begin
      cnt_r <= flags_r[FLG_OMIT] ? CNT_OMIT : CNT_EXEC;
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Ready and done handshake
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      instReady_r <= 1'b0;
      instDone_r  <= 1'b0;
    end
    else
    begin
      instDone_r  <= (state_r == ST_HOLD) && (cnt_r == 4'h0);
      instReady_r <= (state_nxt == ST_IDLE);
    end
  end

  // Latch the decoded instruction and its pointer at hand-in
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      op_r      <= MPA_OP_NONE;
      ptrMode_r <= 3'h0;
      ptrBase_r <= 16'h0000;
    end
    else if (accept)
    begin
      op_r      <= decOp;
      ptrMode_r <= instByte1[2:0];
      ptrBase_r <= pairValue(pairOf(instByte1[2:0]), regB_r, regC_r, regD_r, regE_r, regH_r, regL_r);
    end
  end

  // Memory read: one strobe, address is the pair before any update
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      memRd_r   <= 1'b0;
      memAddr_r <= '0;
    end
    else
    begin
      memRd_r <= accept && !flags_r[FLG_OMIT] && decOk;
      if (accept)
      begin
        memAddr_r <= ADDR_W'(pairValue(pairOf(instByte1[2:0]), regB_r, regC_r, regD_r, regE_r, regH_r,
                                       regL_r));
      end
    end
  end

  // Accumulator
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      acc_r <= RST_BYTE;
    end
    else if (doExec)
    begin
      acc_r <= aluRes;
    end
    else if (swWrite && (regAddr == REG_ACC))
    begin
      acc_r <= regWrData;
    end
  end

  // Register pairs: pointer write-back in the execute state, at the same edge that consumes the read data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      regB_r <= RST_BYTE;
      regC_r <= RST_BYTE;
      regD_r <= RST_BYTE;
      regE_r <= RST_BYTE;
      regH_r <= RST_BYTE;
      regL_r <= RST_BYTE;
    end
    else if (doExec)
    begin
      case (pairId)
        PAIR_BC: {regB_r, regC_r} <= ptrNext;
        PAIR_DE: {regD_r, regE_r} <= ptrNext;
        default: {regH_r, regL_r} <= ptrNext;
      endcase
    end
    else if (swWrite)
    begin
      case (regAddr)
        REG_B:   regB_r <= regWrData;
        REG_C:   regC_r <= regWrData;
        REG_D:   regD_r <= regWrData;
        REG_E:   regE_r <= regWrData;
        REG_H:   regH_r <= regWrData;
        REG_L:   regL_r <= regWrData;
        default: regB_r <= regB_r;
      endcase
    end
  end

  // Flags: execution, omission consumption and software load
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flags_r <= RST_FLAGS;
    end
    else if (doExec)
    begin
      flags_r[FLG_ZERO]    <= aluZero;
      flags_r[FLG_OMIT]    <= aluSkip;
      flags_r[FLG_LOAD_LO] <= 1'b0;
      flags_r[FLG_LOAD_HI] <= 1'b0;
      if (aluArith)
      begin
        flags_r[FLG_CARRY] <= aluCarry;
        flags_r[FLG_HALF]  <= aluHalf;
      end
    end
    else if (accept && flags_r[FLG_OMIT])
    begin
      flags_r[FLG_OMIT] <= 1'b0;
    end
    else if (swWrite && (regAddr == REG_FLAGS))
    begin
      flags_r <= regWrData[FLG_WIDTH-1:0];
    end
  end

  // Omission visible on a pin
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      omitActive_r <= 1'b0;
    end
    else
    begin
      omitActive_r <= flags_r[FLG_OMIT];
    end
  end

  // Unknown opcode or pointer code zero; a new event beats the software clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      illegal_r <= 1'b0;
    end
    else if (accept && !flags_r[FLG_OMIT] && !decOk)
    begin
      illegal_r <= 1'b1;
    end
    else if (regWr && (regAddr == REG_STATUS) && regWrData[STS_ILLEGAL])
    begin
      illegal_r <= 1'b0;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      regRdData_r <= 8'h00;
    end
    else if (regRd)
    begin
      case (regAddr)
        REG_ACC:    regRdData_r <= acc_r;
        REG_B:      regRdData_r <= regB_r;
        REG_C:      regRdData_r <= regC_r;
        REG_D:      regRdData_r <= regD_r;
        REG_E:      regRdData_r <= regE_r;
        REG_H:      regRdData_r <= regH_r;
        REG_L:      regRdData_r <= regL_r;
        REG_FLAGS:  regRdData_r <= {2'b00, flags_r};
        REG_STATUS: regRdData_r <= {6'h00, illegal_r, (state_r != ST_IDLE)};
        default:    regRdData_r <= 8'h00;
      endcase
    end
    else
    begin
      regRdData_r <= 8'h00;
    end
  end

endmodule

// ===== verif/mpa_data_mem.sv
// Behavioural data memory answering the block's read strobe
`timescale 1ns/1ps
module mpa_data_mem
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              sys_clk,
  input wire logic [ADDR_W-1:0] memAddr_r,
  input wire logic              memRd_r,
  output logic [7:0]            memRdData
);
  initial memRdData = 8'h00;
  // Content is a fixed hash of the address; between reads the byte toggles so stale data never passes
  always @(posedge sys_clk)
    if (memRd_r)
      memRdData <= 8'(memAddr_r) ^ 8'(memAddr_r >> 8) ^ 8'h5A;
    else
      memRdData <= ~memRdData;
endmodule

// ===== verif/mpa_mem_pair_alu_checker.sv
// Port-level assertions for the memory-pair ALU block
`timescale 1ns/1ps
module mpa_mem_pair_alu_checker
  import mpa_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              instValid,
  input wire logic [7:0]        instByte0,
  input wire logic [7:0]        instByte1,
  input wire logic              instReady_r,
  input wire logic              instDone_r,
  input wire logic              omitActive_r,
  input wire logic [ADDR_W-1:0] memAddr_r,
  input wire logic              memRd_r,
  input wire logic [7:0]        memRdData,
  input wire logic [3:0]        regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdData_r
);
  logic take;
  // An instruction is taken only where offer and ready meet
  assign take = instValid && instReady_r;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_BUSY_TIME: assert property (take |=> !instReady_r [*7])
    else $error("ready back too early");
  // Done is launched at the eighth or eleventh edge after the take, so it is sampled one edge later
  AST_DONE_TIME: assert property (take |-> (##9 instDone_r or ##12 instDone_r))
    else $error("done not at 8 or 11");
  AST_READ_AFTER_TAKE: assert property (memRd_r |-> $past(take))
    else $error("read without take");
  AST_ONE_READ: assert property (memRd_r |=> !memRd_r [*8])
    else $error("second read");
  AST_BAD_FIRST: assert property (take && instByte0 != FIRST_BYTE |=> !memRd_r)
    else $error("read on foreign byte");
  AST_NO_PTR: assert property (take && instByte1[2:0] == 3'h0 |=> !memRd_r)
    else $error("read on pointer zero");
  AST_ADDR_HOLD: assert property (!$past(take) |-> $stable(memAddr_r))
    else $error("address moved");
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData_r == 8'h00)
    else $error("read data outside slot");
  COV_READ: cover property (memRd_r);
  COV_OMIT: cover property ($rose(omitActive_r));
  COV_SHORT: cover property (take ##9 instDone_r);
  COV_LONG: cover property (take ##12 instDone_r);
endmodule

bind mpa_mem_pair_alu mpa_mem_pair_alu_checker #(.ADDR_W(ADDR_W)) chk (
  .sys_clk(sys_clk), .rst(rst), .instValid(instValid), .instByte0(instByte0),
  .instByte1(instByte1), .instReady_r(instReady_r), .instDone_r(instDone_r),
  .omitActive_r(omitActive_r), .memAddr_r(memAddr_r), .memRd_r(memRd_r),
  .memRdData(memRdData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData_r(regRdData_r));

// ===== verif/mpa_mem_pair_alu_bench.sv
// Self-checking bench for the memory-pair ALU block
`timescale 1ns/1ps
module mpa_mem_pair_alu_bench
  import mpa_pkg::*;
;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        instValid = 1'h0;
  logic [7:0]  instByte0 = 8'h00;
  logic [7:0]  instByte1 = 8'h00;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        regWr = 1'h0;
  logic        regRd = 1'h0;
  logic        instReady_r, instDone_r, omitActive_r, memRd_r;
  logic [15:0] memAddr_r;
  logic [7:0]  memRdData, regRdData_r;
  int          bad_count = 0;
  int          checks = 0;
  int          seed = 21900;
  logic [4:0]  codes [7] = '{CODE_ADC, CODE_ADDNC, CODE_SUB, CODE_SBB, CODE_SUBNB, CODE_AND, CODE_OR};
  logic [15:0] bad [3] = '{{8'h71, CODE_ADC, 3'h1}, {FIRST_BYTE, CODE_ADC, 3'h0}, {FIRST_BYTE, 5'h00, 3'h1}};

  initial
    forever #10 sys_clk = ~sys_clk;

  mpa_mem_pair_alu #(.ADDR_W(16)) uut (
    .sys_clk(sys_clk), .rst(rst), .instValid(instValid), .instByte0(instByte0),
    .instByte1(instByte1), .instReady_r(instReady_r), .instDone_r(instDone_r),
    .omitActive_r(omitActive_r), .memAddr_r(memAddr_r), .memRd_r(memRd_r),
    .memRdData(memRdData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData_r(regRdData_r));

  mpa_data_mem #(.ADDR_W(16)) memModel (
    .sys_clk(sys_clk), .memAddr_r(memAddr_r), .memRd_r(memRd_r), .memRdData(memRdData));

  // Expected memory byte, same hash as the memory model
  function automatic logic [7:0] memf(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction

  // Expected {flags, acc}; borrow shows as bit 8 of the 9-bit difference
  function automatic logic [13:0] model(input logic [4:0] c, input logic [7:0] a, input logic [7:0] m,
                                        input logic [5:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    logic       sub;
    ci = (c == CODE_ADC || c == CODE_SBB) ? f[0] : 1'h0;
    sub = c inside {CODE_SUB, CODE_SBB, CODE_SUBNB};
    s = sub ? {1'h0, a} - {1'h0, m} - 9'(ci) : {1'h0, a} + {1'h0, m} + 9'(ci);
    h = sub ? {1'h0, a[3:0]} - {1'h0, m[3:0]} - 5'(ci) : {1'h0, a[3:0]} + {1'h0, m[3:0]} + 5'(ci);
    if (c == CODE_AND || c == CODE_OR)
    begin
      s[7:0] = (c == CODE_AND) ? a & m : a | m;
      return {3'h0, s[7:0] == 8'h00, f[1:0], s[7:0]};
    end
    return {2'h0, (c == CODE_ADDNC || c == CODE_SUBNB) && !s[8], s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the cycle after
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    d = regRdData_r;
  endtask

  // Offer one instruction while idle; count edges to done, note any read
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, output int n, output logic rd,
                     output logic [15:0] ad);
    rd = 1'h0;
    ad = 16'h0000;
    @(posedge sys_clk);
    instValid <= 1'h1;
    instByte0 <= b0;
    instByte1 <= b1;
    @(posedge sys_clk);
    instValid <= 1'h0;
    // The read strobe stands only in the cycle right after the take
    #1;
    if (memRd_r === 1'h1)
    begin
      rd = 1'h1;
      ad = memAddr_r;
    end
    for (n = 1; n <= 20; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (memRd_r === 1'h1)
      begin
        rd = 1'h1;
        ad = memAddr_r;
      end
      if (instDone_r === 1'h1)
      begin
        check(16'(instReady_r), 16'h0001);
        return;
      end
    end
    bad_count++;
    complete_run();
  endtask

  initial
  begin
    logic [7:0]  rv [7];
    logic [7:0]  d;
    logic [7:0]  lo;
    logic [5:0]  fl;
    logic [13:0] e;
    logic [15:0] pv;
    logic [15:0] ad;
    logic        rd;
    logic [2:0]  p;
    logic [4:0]  c;
    int          n;
    int          pi;
    int          dl;
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    // All places, one unmapped among them, read zero after reset
    for (int a = 0; a < 10; a++)
    begin
      reg_rd(4'(a), d);
      check(16'(d), 16'h0000);
    end
    $display("reset test done");
    // Refused encodings take full time, never read, and leave a sticky error
    foreach (bad[i])
    begin
      run(bad[i][15:8], bad[i][7:0], n, rd, ad);
      check({n[14:0], rd}, 16'h0016);
      reg_rd(REG_STATUS, d);
      check(16'(d), 16'h0002);
      reg_wr(REG_STATUS, 8'h02);
    end
    $display("refusal test done");
    // Every op with every pointer, then random ones; every third uses a wrap corner
    for (int i = 0; i < 70; i++)
    begin
      c = codes[i < 49 ? i / 7 : $unsigned($random(seed)) % 7];
      p = 3'(i < 49 ? i % 7 + 1 : $unsigned($random(seed)) % 7 + 1);
      pi = (p == PTR_BC) ? 0 : (p[0] ? 2 : 1);
      dl = (p == PTR_DE_INC || p == PTR_HL_INC) ? 1 : (p >= PTR_DE_DEC ? -1 : 0);
      foreach (rv[k])
        rv[k] = 8'($random(seed));
      if (i % 3 == 0)
        {rv[1 + 2 * pi], rv[2 + 2 * pi]} = dl < 0 ? 16'h0000 : 16'hFFFF;
      fl = 6'($random(seed)) & 6'h37;
      foreach (rv[k])
        reg_wr(4'(k), rv[k]);
      reg_wr(REG_FLAGS, {2'h0, fl});
      pv = {rv[1 + 2 * pi], rv[2 + 2 * pi]};
      e = model(c, rv[0], memf(pv), fl);
      run(FIRST_BYTE, {c, p}, n, rd, ad);
      check({n[14:0], rd}, 16'h0017);
      check(ad, pv);
      check(16'(omitActive_r), 16'(e[11]));
      reg_rd(REG_ACC, d);
      check(16'(d), 16'(e[7:0]));
      reg_rd(REG_FLAGS, d);
      check(16'(d), 16'(e[13:8]));
      reg_rd(4'(1 + 2 * pi), d);
      reg_rd(4'(2 + 2 * pi), lo);
      check({d, lo}, pv + 16'(dl));
      if (e[11])
      begin
        run(FIRST_BYTE, {CODE_OR, PTR_BC}, n, rd, ad);
        check({n[14:0], rd}, 16'h0010);
        check(16'(omitActive_r), 16'h0000);
        reg_rd(REG_ACC, d);
        check(16'(d), 16'(e[7:0]));
      end
      $display("op test %0d done", i);
    end
    complete_run();
  end
endmodule
